// File: verilog/tcs_timer.sv
// 8-bit interval timer/counter with start-bit detection and serial latches.
// Assumes an APB master on clk_sys_i and asynchronous pins on the far side.
//
// How it works
// - 8-bit up-counter, 8-bit preload and 8-bit control register.
// - Two control bits pick MCLK, ACLK, pin, or MCLK AND pin clock.
// - Writing the counter copies the preload into it, ignoring data.
// - Preload is read/write and may be rewritten right after a load.
// - Counter steps on each selected clock edge while enabled and the receive buffer has room.
// - With start detection on, counting waits for a start-bit edge.
// - At the end of every interval the serial input is sampled.
// - Carry-out clocks both the receive and transmit latches.
// - Transmit bit leaves one per interval; software frames the bits.
// - Count pin and serial output pin are shared with the port.
//
// Design decisions made here: the register offsets and register access over APB.
module tcs_timer
    import tcs_pkg::*;
#(
    parameter int ACLK_DIV  = ACLK_DIV_DEF,
    parameter int BUF_DEPTH = 2
) (
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    input  wire logic        ext_count_pin_i,
    input  wire logic        rx_serial_i,
    output logic             serial_out_pin_o,
    output logic             serial_out_sel_o,
    output logic             carry_o,
    output logic             rx_bit_o,
    output logic             rx_valid_o,
    input  wire logic        rx_ready_i
);
    typedef struct packed {
        logic [7:0]  cnt;
        logic [7:0]  pld;
        logic [7:0]  ctl;
        tcs_state_t  state;
        logic        rx_latch;
        logic        tx_latch;
        logic        carry;
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_s3;
        logic        rx_s1;
        logic        rx_s2;
        logic        rx_s3;
        logic [7:0]  aclk_cnt;
        logic        aclk_en;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tcs_st_t;

    tcs_st_t r;
    tcs_st_t n;

    logic       ext_rise;
    logic       rx_fall;
    logic       src;
    logic       tick;
    logic       roll;
    logic       acc;
    logic       done;
    logic       hit_ctl;
    logic       hit_pld;
    logic       hit_dat;
    logic       wr_ctl;
    logic       wr_pld;
    logic       wr_dat;
    logic       buf_ready;
    logic [1:0] sel;

    tcs_buf #(
        .W     (1),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (roll),
        .in_ready_o  (buf_ready),
        .in_data_i   (r.rx_s2),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_bit_o)
    );

    always_comb begin
        n = r;
        // Pin synchronisers; only stage 2 and 3 feed logic
        n.ext_s1 = ext_count_pin_i;
        n.ext_s2 = r.ext_s1;
        n.ext_s3 = r.ext_s2;
        n.rx_s1  = rx_serial_i;
        n.rx_s2  = r.rx_s1;
        n.rx_s3  = r.rx_s2;
        ext_rise = r.ext_s2 && !r.ext_s3;
        rx_fall  = !r.rx_s2 && r.rx_s3;

        // Auxiliary clock as an enable pulse
        n.aclk_en = 1'b0;
        if (r.aclk_cnt == 8'(ACLK_DIV - 1)) begin
            n.aclk_cnt = 8'h00;
            n.aclk_en  = 1'b1;
        end else begin
            n.aclk_cnt = 8'(r.aclk_cnt + 8'h01);
        end

        sel = r.ctl[CTL_SEL0 +: 2];
        case (sel)
            SEL_MCLK: src = 1'b1;
            SEL_ACLK: src = r.aclk_en;
            SEL_EXT:  src = ext_rise;
            SEL_AND:  src = r.ext_s2;
            default:  src = 1'b0;
        endcase

        // APB: one wait state, then the completing edge
        acc     = psel_i && penable_i;
        done    = acc && r.pready;
        hit_ctl = (paddr_i == ADDR_CTL);
        hit_pld = (paddr_i == ADDR_PLD);
        hit_dat = (paddr_i == ADDR_DAT);
        wr_ctl  = done && pwrite_i && pstrb_i[0] && hit_ctl;
        wr_pld  = done && pwrite_i && pstrb_i[0] && hit_pld;
        wr_dat  = done && pwrite_i && hit_dat;
        n.pready  = acc && !r.pready;
        n.pslverr = 1'b0;
        n.prdata  = 32'h0000_0000;
        if (acc && !r.pready) begin
            n.pslverr = !(hit_ctl || hit_pld || hit_dat);
            if (hit_ctl) begin
                n.prdata[7:0] = {r.state == ST_WAIT,
                                 r.ctl[CTL_TXSEL:CTL_TXBIT], r.rx_latch};
            end else if (hit_pld) begin
                n.prdata[7:0] = r.pld;
            end else if (hit_dat) begin
                n.prdata[7:0] = r.cnt;
            end
        end
        if (wr_ctl) begin
            n.ctl = pwdata_i[7:0] & CTL_WR_MASK;
        end
        if (wr_pld) begin
            n.pld = pwdata_i[7:0];
        end

        // Counting stalls while the receive buffer is full
        tick = (r.state == ST_RUN) && r.ctl[CTL_CNTEN] && src
               && buf_ready;
        roll = tick && !wr_dat && (r.cnt == CNT_MAX);
        n.carry = 1'b0;
        if (wr_dat) begin
            n.cnt = r.pld;
        end else if (roll) begin
            n.cnt      = r.pld;
            n.carry    = 1'b1;
            n.rx_latch = r.rx_s2;
            n.tx_latch = r.ctl[CTL_TXBIT];
        end else if (tick) begin
            n.cnt = 8'(r.cnt + 8'h01);
        end

        case (r.state)
            ST_IDLE: begin
                if (r.ctl[CTL_CNTEN]) begin
                    n.state = r.ctl[CTL_SDEN] ? ST_WAIT : ST_RUN;
                end
            end
            ST_WAIT: begin
                if (!r.ctl[CTL_CNTEN]) begin
                    n.state = ST_IDLE;
                end else if (rx_fall) begin
                    n.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!r.ctl[CTL_CNTEN]) begin
                    n.state = ST_IDLE;
                end
            end
            default: n.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            r          <= '0;
            r.cnt      <= RST_CNT;
            r.pld      <= RST_PLD;
            r.ctl      <= RST_CTL;
            r.state    <= ST_IDLE;
            r.tx_latch <= RST_TX;
            r.rx_latch <= 1'b1;
            r.ext_s1   <= 1'b0;
            r.rx_s1    <= 1'b1;
            r.rx_s2    <= 1'b1;
            r.rx_s3    <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign pready_o         = r.pready;
    assign prdata_o         = r.prdata;
    assign pslverr_o        = r.pslverr;
    assign serial_out_pin_o = r.tx_latch;
    assign serial_out_sel_o = r.ctl[CTL_TXSEL];
    assign carry_o          = r.carry;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_start_seen;
        (r.state == ST_WAIT) && r.ctl[CTL_CNTEN] && rx_fall;
    endsequence

    sequence s_rollover;
        tick && !wr_dat && (r.cnt == CNT_MAX);
    endsequence

    AST_LOAD_PRELOAD:
    assert property (wr_dat |=> r.cnt == $past(r.pld))
        else $error("counter write did not load preload");

    AST_PLD_WRITE:
    assert property (wr_pld |=> r.pld == $past(pwdata_i[7:0]))
        else $error("preload write not stored");

    AST_COUNT_HOLD:
    assert property (!tick && !wr_dat |=> $stable(r.cnt))
        else $error("counter moved without a count edge");

    AST_COUNT_INC:
    assert property (tick && !wr_dat && r.cnt != CNT_MAX
                     |=> r.cnt == $past(r.cnt) + 8'h01)
        else $error("counter did not step by one");

    AST_MCLK_TICK:
    assert property (r.state == ST_RUN && r.ctl[CTL_CNTEN] && buf_ready
                     && sel == SEL_MCLK |-> tick)
        else $error("master clock selection did not count");

    AST_START_WAIT:
    assert property (r.state == ST_WAIT && !wr_dat
                     |=> $stable(r.cnt) && !carry_o)
        else $error("counting before start bit");

    AST_START_RUN:
    assert property (s_start_seen |=> r.state == ST_RUN)
        else $error("start bit edge did not start counter");

    AST_RX_CAPTURE:
    assert property (s_rollover |=> carry_o
                     && r.rx_latch == $past(r.rx_s2))
        else $error("receive latch not clocked by carry");

    AST_TX_LATCH:
    assert property (s_rollover |=> serial_out_pin_o
                     == $past(r.ctl[CTL_TXBIT])
                     ##1 (!carry_o || $past(r.pld, 2) == CNT_MAX))
        else $error("transmit latch not clocked by carry");

    AST_CARRY_ONLY_ROLL:
    assert property ($rose(carry_o) |-> $past(r.cnt) == CNT_MAX
                     && r.cnt == $past(r.pld))
        else $error("carry without rollover");

    AST_TX_STABLE:
    assert property (!carry_o |-> $stable(serial_out_pin_o))
        else $error("serial output changed between intervals");

    AST_PLD_READ:
    assert property (acc && !r.pready && hit_pld
                     |=> prdata_o[7:0] == $past(r.pld))
        else $error("preload read returned wrong value");

    AST_DAT_READ:
    assert property (acc && !r.pready && hit_dat
                     |=> prdata_o[7:0] == $past(r.cnt))
        else $error("counter read returned wrong value");

    AST_STRB_IGNORE:
    assert property (done && pwrite_i && hit_pld && !pstrb_i[0]
                     |=> $stable(r.pld))
        else $error("preload written with lane 0 strobe low");

    AST_PIN_SHARE:
    assert property (wr_ctl
                     |=> serial_out_sel_o == $past(pwdata_i[CTL_TXSEL]))
        else $error("pin select does not follow control write");

    AST_AND_COUNT:
    assert property (tick && sel == SEL_AND && !wr_dat && r.cnt != CNT_MAX
                     |=> r.cnt == $past(r.cnt) + 8'h01 && $past(r.ext_s2))
        else $error("gated clock counted while pin low");

endmodule

// File: verilog/tcs_pkg.sv
// Constants, register map and state codes of the 8-bit interval timer.
// Assumes a 32-bit APB slave port; register byte address is 4x index.
package tcs_pkg;

    // Register indices and their byte addresses
    localparam logic [7:0]  IDX_CTL  = 8'h42;
    localparam logic [7:0]  IDX_PLD  = 8'h43;
    localparam logic [7:0]  IDX_DAT  = 8'h44;
    localparam logic [11:0] ADDR_CTL = {2'h0, IDX_CTL, 2'h0};
    localparam logic [11:0] ADDR_PLD = {2'h0, IDX_PLD, 2'h0};
    localparam logic [11:0] ADDR_DAT = {2'h0, IDX_DAT, 2'h0};

    // Control register fields
    localparam int CTL_RXBIT = 0;
    localparam int CTL_TXBIT = 1;
    localparam int CTL_SDEN  = 2;
    localparam int CTL_CNTEN = 3;
    localparam int CTL_SEL0  = 4;
    localparam int CTL_TXSEL = 6;
    localparam int CTL_WAIT  = 7;
    localparam logic [7:0] CTL_WR_MASK = 8'h7e;

    // Count clock selections
    localparam logic [1:0] SEL_MCLK = 2'h0;
    localparam logic [1:0] SEL_ACLK = 2'h1;
    localparam logic [1:0] SEL_EXT  = 2'h2;
    localparam logic [1:0] SEL_AND  = 2'h3;

    // Reset values and counter maximum
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [7:0] RST_PLD = 8'h00;
    localparam logic [7:0] RST_CNT = 8'h00;
    localparam logic       RST_TX  = 1'b1;
    localparam logic [7:0] CNT_MAX = 8'hff;

    // Master clock is this multiple of the auxiliary clock after reset
    localparam int ACLK_DIV_DEF = 32;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } tcs_state_t;

endpackage

// File: verilog/tcs_buf.sv
// Small shift-style FIFO; entry 0 is the head and drives the output.
// Assumes both sides on clk_sys_i; out_valid/out_data come from flops.
module tcs_buf #(
    parameter int W     = 1,
    parameter int DEPTH = 2
) (
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] data;
        logic [CW-1:0]           cnt;
        logic                    vld;
    } tcs_buf_st_t;

    tcs_buf_st_t r;
    tcs_buf_st_t n;
    logic        push;
    logic        pop;
    logic [CW-1:0] wpos;

    assign in_ready_o  = (r.cnt != CW'(DEPTH));
    assign out_valid_o = r.vld;
    assign out_data_o  = r.data[0];

    always_comb begin
        n    = r;
        push = in_valid_i && in_ready_o;
        pop  = out_valid_o && out_ready_i;
        wpos = pop ? CW'(r.cnt - 1'b1) : r.cnt;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                n.data[i] = r.data[i+1];
            end
        end
        if (push) begin
            n.data[wpos] = in_data_i;
        end
        n.cnt = CW'(r.cnt + CW'(push) - CW'(pop));
        n.vld = (n.cnt != '0);
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

// File: tb/tcs_far_end.sv
// Far-end model: pulse source on the count pin and serial line driver.
// Assumes the bench calls its tasks right after a rising clock edge.
module tcs_far_end (
    input  wire logic clk_sys_i,
    output logic      ext_count_pin_o,
    output logic      rx_serial_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ext_count_pin_o = 1'b0;
        rx_serial_o     = 1'b1;
    end
    // Slow pulses, three cycles high and four low
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_sys_i) ext_count_pin_o <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
            ext_count_pin_o <= 1'b0;
            repeat (3) @(posedge clk_sys_i);
        end
    endtask
    task automatic line(input logic v);
        @(posedge clk_sys_i) rx_serial_o <= v;
    endtask
endmodule

// File: tb/tb_top.sv
// Bench for the interval timer: APB tasks and sequenced tests.
// Assumes the far-end model drives the pins; ACLK_DIV shortened to 4.
module tb_top
    import tcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i;
    logic        sys_rst_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        pready_o;
    logic [31:0] prdata_o;
    logic        pslverr_o;
    logic        pin;
    logic        rx;
    logic        serial_out_pin_o;
    logic        serial_out_sel_o;
    logic        carry_o;
    logic        rx_bit_o;
    logic        rx_valid_o;
    logic        rx_ready;
    logic [31:0] rdat;
    logic        rerr;
    int          num_errors = 0;
    int          n_checks = 0;
    int          n_carry = 0;
    int          c0;

    tcs_timer #(.ACLK_DIV(4), .BUF_DEPTH(2)) i_tcs_timer (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready_o),
        .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .ext_count_pin_i(pin), .rx_serial_i(rx),
        .serial_out_pin_o(serial_out_pin_o),
        .serial_out_sel_o(serial_out_sel_o), .carry_o(carry_o),
        .rx_bit_o(rx_bit_o), .rx_valid_o(rx_valid_o),
        .rx_ready_i(rx_ready));
    tcs_far_end i_tcs_far_end (.clk_sys_i(clk_sys_i),
        .ext_count_pin_o(pin), .rx_serial_o(rx));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (carry_o === 1'b1) n_carry <= n_carry + 1;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int k;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        if (k >= 50) begin
            num_errors++;
            test_done();
        end
        rdat = prdata_o;
        rerr = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string n, input logic [11:0] a,
                       input logic [7:0] x, input logic [7:0] m);
        apb(1'b0, a, 8'h00);
        chk(n, rdat & {24'h0, m}, {24'h0, x});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    initial begin
        sys_rst_i = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        rx_ready = 1'b1;
        cyc(12);
        sys_rst_i <= 1'b0;
        rdc("ctl", ADDR_CTL, RST_CTL | 8'h01, 8'hff);
        rdc("pld", ADDR_PLD, RST_PLD, 8'hff);
        rdc("dat", ADDR_DAT, RST_CNT, 8'hff);
        chk("tx_idle", serial_out_pin_o, RST_TX);
        apb(1'b0, 12'h000, 8'h00);
        chk("unmapped", rerr, 1'b1);
        wr_load(8'hfe);
        rdc("pld", ADDR_PLD, 8'hfe, 8'hff);
        rdc("load", ADDR_DAT, 8'hfe, 8'hff);
        pstrb <= 4'he;
        apb(1'b1, ADDR_PLD, 8'h12);
        pstrb <= 4'hf;
        rdc("strb", ADDR_PLD, 8'hfe, 8'hff);
        $display("test registers done");
        apb(1'b1, ADDR_CTL, 8'h48);
        cyc(6);
        c0 = n_carry;
        cyc(20);
        chk("carries", n_carry - c0, 10);
        chk("tx0", serial_out_pin_o, 1'b0);
        chk("pin_sel", serial_out_sel_o, 1'b1);
        apb(1'b1, ADDR_CTL, 8'h4a);
        cyc(6);
        chk("tx1", serial_out_pin_o, 1'b1);
        i_tcs_far_end.line(1'b0);
        cyc(10);
        rx_ready <= 1'b0;
        cyc(20);
        c0 = n_carry;
        cyc(10);
        chk("stall", n_carry - c0, 0);
        chk("rx_valid", rx_valid_o, 1'b1);
        chk("rx_bit", rx_bit_o, 1'b0);
        rx_ready <= 1'b1;
        $display("test interval done");
        i_tcs_far_end.line(1'b1);
        cyc(10);
        apb(1'b1, ADDR_CTL, 8'h00);
        rdc("rx_latch", ADDR_CTL, 8'h01, 8'h01);
        apb(1'b1, ADDR_DAT, 8'h00);
        apb(1'b1, ADDR_CTL, 8'h0c);
        c0 = n_carry;
        cyc(20);
        chk("idle", n_carry - c0, 0);
        rdc("waiting", ADDR_CTL, 8'h80, 8'h80);
        i_tcs_far_end.line(1'b0);
        cyc(10);
        rdc("started", ADDR_CTL, 8'h00, 8'h81);
        chk("run", n_carry != c0, 1'b1);
        $display("test start detect done");
        apb(1'b1, ADDR_CTL, 8'h00);
        wr_load(8'h00);
        apb(1'b1, ADDR_CTL, 8'h28);
        i_tcs_far_end.pulses(5);
        cyc(6);
        rdc("edge_count", ADDR_DAT, 8'h05, 8'hff);
        apb(1'b1, ADDR_CTL, 8'h38);
        i_tcs_far_end.pulses(2);
        cyc(20);
        apb(1'b1, ADDR_CTL, 8'h00);
        rdc("pin_count", ADDR_DAT, 8'h0b, 8'hff);
        apb(1'b1, ADDR_DAT, 8'h00);
        apb(1'b1, ADDR_CTL, 8'h18);
        cyc(40);
        apb(1'b1, ADDR_CTL, 8'h00);
        apb(1'b0, ADDR_DAT, 8'h00);
        chk("aclk", rdat > 32'h5 && rdat < 32'h14, 1'b1);
        $display("test clock select done");
        test_done();
    end
    task automatic wr_load(input logic [7:0] v);
        apb(1'b1, ADDR_PLD, v);
        apb(1'b1, ADDR_DAT, 8'h55);
    endtask
endmodule
